// ===== hw/amso_ctrl.sv
// Sync, overflow flagging and command control of the four-channel acquisition module
// Summary of operation
// - Separate overflow flag per channel, readable
// - Flags enter packets with no delay
// - Sub-period overflow still reaches one packet
// - Flag repeats while overflow persists, then clears
// - Flag follows converter limit, not subrange
// - Phase alignment and output start are separate
// - First output sample is the first one after the sync instant
// - Five start procedures supported
// - Master emits sync pulse for all modules
// - Sync input acts on edges only
// - Master idles low; slave output floats
// - Sync pulse lasts several microseconds
// - Stop, reset, load handled purely by hardware
// - First instruction command starts operating cycle
// - Calibration factors per channel and range, read-only
// - Reset command holds converters, stop releases
// - Output waits for 8192-sample self-calibration; output already running stays on through an align procedure
// - Rolling counter cleared by reset, counts packets
// - Range field shows 7 during overflow
`timescale 1ns/10ps
module amso_ctrl
	import amso_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Crate commands, one-cycle pulses from the interface decoder
	input wire logic cmd_stop,
	input wire logic cmd_reset,
	input wire logic program_load_command,
	input wire logic instruction_command,
	input wire logic inbound_data,
	// Procedure request from the microcontroller
	input wire logic proc_go,
	input wire logic [2:0] proc_sel,
	// Converter side
	input wire logic sample_strobe,
	input wire logic [N_CHAN*SAMPLE_W-1:0] sample_data,
	input wire logic [N_CHAN-1:0] ovf_comp,
	input wire logic [N_CHAN*3-1:0] chan_range,
	input wire logic [N_CHAN-1:0] chan_enable,
	output logic conv_reset,
	// Calibration store read port
	input wire logic [4:0] cal_addr,
	output logic [2*CAL_W-1:0] cal_rdata,
	// Sync pins
	input wire logic sync_input,
	output logic sync_output_o,
	output logic sync_output_oe_n,
	// Status
	output logic [N_CHAN-1:0] ovf_status,
	output logic mcu_active,
	output logic prog_load_req,
	output logic inbound_refused,
	output logic out_running,
	// Outbound packet stream
	output logic pkt_valid,
	input wire logic pkt_ready,
	output logic [PKT_W-1:0] pkt_data
);
	amso_state_e state;
	logic [2:0] sync_ff;
	logic sync_seen;
	logic sync_edge;
	logic [N_CHAN-1:0] ovf_hold;
	logic [N_CHAN-1:0] ovf_live;
	logic [N_CHAN-1:0] ovf_snap;
	logic go_master;
	logic [2:0] rolling_sample_counter;
	logic [13:0] cal_cnt;
	logic [PULSE_W-1:0] pulse_cnt;
	logic master;
	logic aligning;
	logic wait_start;
	logic [1:0] chan_idx;
	logic [N_CHAN*SAMPLE_W-1:0] smp_buf;
	logic [N_CHAN-1:0] smp_pend;
	logic f_valid;
	logic f_ready;
	logic [PKT_W-1:0] f_data;
	logic fo_valid;
	logic [PKT_W-1:0] fo_data;
	logic [2*CAL_W-1:0] cal_rom [32];
	logic [2*CAL_W-1:0] next_cal_rdata;

	// Three stages; the change is taken when stages two and three agree on a new value
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_ff <= 3'h0;
			sync_seen <= 1'b0;
		end else if (clk_en) begin
			sync_ff <= {sync_ff[1:0], sync_input};
			if (sync_ff[2] == sync_ff[1]) begin
				sync_seen <= sync_ff[2];
			end
		end
	end
	assign sync_edge = (sync_ff[2] == sync_ff[1]) && sync_ff[2] && !sync_seen;

	// Pulse only for an accepted master procedure; commands take priority over it
	assign go_master = proc_go && mcu_active && !cmd_reset && !cmd_stop &&
		(proc_sel == AMSO_ALIGN_MASTER || proc_sel == AMSO_START_MASTER);

	// Master pulse: pulse width counter; output floats in slave role
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pulse_cnt <= '0;
			sync_output_o <= 1'b0;
			sync_output_oe_n <= 1'b1;
		end else if (clk_en) begin
			// Drive from the pulse's first cycle, before the role register has settled
			sync_output_oe_n <= !master && !go_master;
			if (go_master) begin
				pulse_cnt <= PULSE_W'(SYNC_PULSE_CYC);
				sync_output_o <= 1'b1;
			end else if (pulse_cnt != '0) begin
				pulse_cnt <= PULSE_W'(pulse_cnt - 1'b1);
				sync_output_o <= (pulse_cnt != PULSE_W'(1));
			end else begin
				sync_output_o <= 1'b0;
			end
		end
	end

	// Command and start-procedure sequencing
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= AMSO_ST_STOP;
			conv_reset <= 1'b0;
			mcu_active <= 1'b0;
			master <= 1'b0;
			aligning <= 1'b0;
			wait_start <= 1'b0;
			cal_cnt <= '0;
			prog_load_req <= 1'b0;
			inbound_refused <= 1'b0;
			out_running <= 1'b0;
		end else if (clk_en) begin
			prog_load_req <= program_load_command;
			inbound_refused <= inbound_data;
			if (instruction_command) begin
				mcu_active <= 1'b1;
			end
			if (cmd_reset) begin
				state <= AMSO_ST_CONV_RST;
				conv_reset <= 1'b1;
				mcu_active <= 1'b0;
				out_running <= 1'b0;
				wait_start <= 1'b0;
				aligning <= 1'b0;
			end else if (cmd_stop) begin
				out_running <= 1'b0;
				wait_start <= 1'b0;
				if (state == AMSO_ST_CONV_RST) begin
					conv_reset <= 1'b0;
					state <= AMSO_ST_CAL;
					cal_cnt <= '0;
				end
			end else if (proc_go && mcu_active) begin
				case (proc_sel)
					AMSO_START_ASYNC: begin
						if (state == AMSO_ST_WAIT) begin
							out_running <= 1'b1;
						end
					end
					AMSO_ALIGN_SLAVE, AMSO_ALIGN_MASTER: begin
						master <= (proc_sel == AMSO_ALIGN_MASTER);
						aligning <= 1'b1;
						conv_reset <= 1'b1;
						state <= AMSO_ST_CONV_RST;
					end
					AMSO_START_SLAVE, AMSO_START_MASTER: begin
						master <= (proc_sel == AMSO_START_MASTER);
						wait_start <= 1'b1;
					end
					default: begin
					end
				endcase
			end else begin
				case (state)
					AMSO_ST_CONV_RST: begin
						if (aligning && sync_edge) begin
							conv_reset <= 1'b0;
							aligning <= 1'b0;
							cal_cnt <= '0;
							state <= AMSO_ST_CAL;
						end
					end
					AMSO_ST_CAL: begin
						if (sample_strobe) begin
							cal_cnt <= 14'(cal_cnt + 1'b1);
							if (cal_cnt == 14'(CAL_SAMPLES - 1)) begin
								state <= AMSO_ST_WAIT;
							end
						end
					end
					AMSO_ST_WAIT: begin
						if (wait_start && sync_edge) begin
							out_running <= 1'b1;
							wait_start <= 1'b0;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Overflow flags: caught sticky between samples so short pulses survive
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ovf_hold <= '0;
			ovf_snap <= '0;
			ovf_status <= '0;
		end else if (clk_en) begin
			ovf_status <= ovf_live;
			if (sample_strobe) begin
				// All that the closing period saw travels with this sample's packets,
				// so a pulse between two channel packets is not lost at the strobe
				ovf_snap <= ovf_live;
				ovf_hold <= ovf_comp;
			end else begin
				ovf_hold <= ovf_hold | ovf_comp;
			end
		end
	end
	// Comparator level is current, never delayed to match the sample pipeline
	assign ovf_live = ovf_hold | ovf_comp;

	// Packetiser: one packet per enabled channel per sample
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			smp_buf <= '0;
			smp_pend <= '0;
			chan_idx <= 2'h0;
			rolling_sample_counter <= CNT_RESET;
		end else if (clk_en) begin
			if (cmd_reset) begin
				rolling_sample_counter <= CNT_RESET;
				smp_pend <= '0;
			end else if (sample_strobe && out_running) begin
				smp_buf <= sample_data;
				smp_pend <= chan_enable;
				chan_idx <= 2'h0;
			end else if (smp_pend != '0) begin
				if (!smp_pend[chan_idx]) begin
					chan_idx <= 2'(chan_idx + 1'b1);
				end else if (f_ready) begin
					smp_pend[chan_idx] <= 1'b0;
					chan_idx <= 2'(chan_idx + 1'b1);
					rolling_sample_counter <= 3'(rolling_sample_counter + 1'b1);
				end
			end
		end
	end
	// A new strobe replaces packets still pending: the period must be at least channels plus one
	assign f_valid = smp_pend[chan_idx] && !cmd_reset && !(sample_strobe && out_running);
	assign f_data = amso_pack(rolling_sample_counter,
		ovf_snap[chan_idx] ? RANGE_OVF : chan_range[chan_idx*3 +: 3],
		chan_idx, smp_buf[chan_idx*SAMPLE_W +: SAMPLE_W]);

	amso_fifo #(.WIDTH(PKT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.in_valid(f_valid),
		.in_ready(f_ready),
		.in_data(f_data),
		.out_valid(fo_valid),
		.out_ready(pkt_ready && (!pkt_valid || pkt_ready)),
		.out_data(fo_data)
	);

	// Output register stage so the stream ports come from flip-flops
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pkt_valid <= 1'b0;
			pkt_data <= '0;
		end else if (clk_en) begin
			if (!pkt_valid || pkt_ready) begin
				pkt_valid <= fo_valid && pkt_ready;
				pkt_data <= fo_data;
			end
		end
	end

	// Factory calibration pairs, fixed in the build; no write path exists
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			cal_rom[i] = {CAL_GAIN_INIT, CAL_OFFSET_INIT};
		end
		next_cal_rdata = cal_rom[cal_addr];
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cal_rdata <= '0;
		end else if (clk_en) begin
			cal_rdata <= next_cal_rdata;
		end
	end
endmodule : amso_ctrl

// ===== hw/amso_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module amso_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready && clk_en;
	assign pop = out_valid && out_ready && clk_en;

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= AW'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= AW'(rd_ptr + 1'b1);
			end
			if (push && !pop) begin
				count <= (AW+1)'(count + 1'b1);
			end else if (pop && !push) begin
				count <= (AW+1)'(count - 1'b1);
			end
		end
	end
endmodule : amso_fifo

// ===== hw/amso_pkg.sv
// Package of constants and types for the acquisition module sync and overflow control
package amso_pkg;
	localparam int CLK_MHZ = 25;
	localparam int N_CHAN = 4;
	localparam int SAMPLE_W = 16;
	localparam int PKT_W = 24;
	// Sync pulse width in microseconds, and its cycle count at the system clock
	localparam int SYNC_PULSE_US = 4;
	localparam int SYNC_PULSE_CYC = SYNC_PULSE_US * CLK_MHZ;
	// Converter self-calibration length in sample periods
	localparam int CAL_SAMPLES = 8192;
	// Pre-trigger sample count; no logic uses it, a synchronised stream starts at the trigger instant
	localparam int PRE_TRIG_SAMPLES = 37;
	localparam logic [2:0] RANGE_OVF = 3'h7;
	localparam logic [2:0] CNT_RESET = 3'h0;
	localparam int FIFO_DEPTH = 32;
	localparam int CAL_W = 14;
	// Factory calibration pair held for every channel and range
	localparam logic [CAL_W-1:0] CAL_GAIN_INIT = 14'h2000;
	localparam logic [CAL_W-1:0] CAL_OFFSET_INIT = 14'h0000;
	localparam int PULSE_W = 8;

	typedef enum logic [2:0] {
		AMSO_START_ASYNC = 3'h0,
		AMSO_ALIGN_SLAVE = 3'h1,
		AMSO_ALIGN_MASTER = 3'h2,
		AMSO_START_SLAVE = 3'h3,
		AMSO_START_MASTER = 3'h4
	} amso_proc_e;

	typedef enum logic [2:0] {
		AMSO_ST_STOP = 3'b000,
		AMSO_ST_CONV_RST = 3'b001,
		AMSO_ST_CAL = 3'b011,
		AMSO_ST_WAIT = 3'b010,
		AMSO_ST_RUN = 3'b110
	} amso_state_e;

	// Assemble one outbound packet from its fields
	function automatic logic [PKT_W-1:0] amso_pack(input logic [2:0] cnt, input logic [2:0] rng,
			input logic [1:0] ch, input logic [SAMPLE_W-1:0] smp);
		amso_pack = {cnt, rng, ch, smp};
	endfunction : amso_pack
endpackage : amso_pkg

// ===== sim/amso_asserts.sv
// Port checker for the acquisition sync and overflow control
`timescale 1ns/10ps
module amso_asserts
	import amso_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Commands
	input wire logic cmd_stop,
	input wire logic cmd_reset,
	input wire logic instruction_command,
	input wire logic inbound_data,
	// Watched outputs and the stream ready input
	input wire logic conv_reset,
	input wire logic mcu_active,
	input wire logic inbound_refused,
	input wire logic sync_output_o,
	input wire logic sync_output_oe_n,
	input wire logic pkt_valid,
	input wire logic pkt_ready,
	input wire logic [PKT_W-1:0] pkt_data
);
	int hi_cnt;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Too long for a repetition, so the pulse length is counted here
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			hi_cnt <= 0;
		else
			hi_cnt <= sync_output_o ? hi_cnt + 1 : 0;
	end
	a_reset_holds_conv: assert property (clk_en && cmd_reset |=> conv_reset)
		else $error("conv reset not set");
	a_stop_frees_conv: assert property (clk_en && cmd_stop && !cmd_reset |=> !conv_reset)
		else $error("conv reset not freed");
	a_instruction_command_starts_mcu: assert property (clk_en && instruction_command |=> mcu_active)
		else $error("mcu not active");
	a_mcu_needs_instruction_command: assert property (!mcu_active && !instruction_command |=> !mcu_active)
		else $error("mcu active unasked");
	a_inbound_refused: assert property (clk_en && inbound_data |=> inbound_refused)
		else $error("inbound not refused");
	a_pkt_held: assert property (pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data))
		else $error("packet dropped");
	a_pulse_length: assert property ($fell(sync_output_o) |-> hi_cnt == SYNC_PULSE_CYC)
		else $error("sync pulse length");
	a_drive_master: assert property (sync_output_o |-> !sync_output_oe_n)
		else $error("sync high undriven");
	cover property ($rose(sync_output_o));
	cover property ($fell(conv_reset));
	cover property (pkt_valid && pkt_ready);
endmodule : amso_asserts

bind amso_ctrl amso_asserts u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
	.cmd_stop(cmd_stop), .cmd_reset(cmd_reset), .instruction_command(instruction_command),
	.inbound_data(inbound_data), .conv_reset(conv_reset), .mcu_active(mcu_active),
	.inbound_refused(inbound_refused), .sync_output_o(sync_output_o),
	.sync_output_oe_n(sync_output_oe_n), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
	.pkt_data(pkt_data));

// ===== sim/amso_crate_model.sv
// Crate controller model: drains the packet stream at a chosen pace
`timescale 1ns/10ps
module amso_crate_model (
	// Clock
	input wire logic sys_clk,
	// Pace: 0 prompt, 1 slow, 2 stalled
	input wire logic [1:0] pace,
	// Stream
	output logic pkt_ready
);
	initial pkt_ready = 1'b0;
	// Outbound only: this side never offers inward data packets
	always @(negedge sys_clk)
		pkt_ready <= pace == 2'h0 || (pace == 2'h1 && $urandom % 4 != 0);
endmodule : amso_crate_model

// ===== sim/tb.sv
// Self-checking bench for the acquisition sync and overflow control
`timescale 1ns/10ps
module tb;
	import amso_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [5:0] cmdv = '0;
	logic [2:0] sel = '0;
	logic strobe = 1'b0;
	logic ext_sync = 1'b0;
	logic [63:0] smp = '0;
	logic [3:0] ovf = '0, seen = '0, lv, en = 4'hf;
	logic [11:0] rng = '0;
	logic [1:0] pace = '0;
	logic [2:0] cnt = '0;
	logic conv_rst, sync_o, sync_oe_n, mcu, plr, refused, running, pv, pr;
	logic [23:0] pd;
	logic [3:0] ovs;
	logic [4:0] ca = '0;
	logic [27:0] cr;
	logic [23:0] exp_q[$];
	int n_fail = 0, checks_done = 0, cyc = 0;
	always #20 sys_clk = ~sys_clk;
	amso_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1), .cmd_stop(cmdv[0]),
		.cmd_reset(cmdv[1]), .program_load_command(cmdv[2]), .instruction_command(cmdv[3]),
		.inbound_data(cmdv[4]), .proc_go(cmdv[5]), .proc_sel(sel), .sample_strobe(strobe),
		.sample_data(smp), .ovf_comp(ovf), .chan_range(rng), .chan_enable(en),
		.conv_reset(conv_rst), .cal_addr(ca), .cal_rdata(cr),
		.sync_input(ext_sync | (!sync_oe_n && sync_o)), .sync_output_o(sync_o),
		.sync_output_oe_n(sync_oe_n), .ovf_status(ovs), .mcu_active(mcu), .prog_load_req(plr),
		.inbound_refused(refused), .out_running(running), .pkt_valid(pv), .pkt_ready(pr),
		.pkt_data(pd));
	amso_crate_model host (.sys_clk(sys_clk), .pace(pace), .pkt_ready(pr));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task cmd(input int k);
		@(negedge sys_clk) cmdv[k] = 1'b1;
		@(negedge sys_clk) cmdv = '0;
	endtask : cmd
	task go(input logic [2:0] s);
		sel = s;
		cmd(5);
	endtask : go
	task trig();
		@(negedge sys_clk) ext_sync = 1'b1;
		repeat (8) @(negedge sys_clk);
		ext_sync = 1'b0;
	endtask : trig
	task cal();
		repeat (CAL_SAMPLES) begin
			@(negedge sys_clk) strobe = 1'b1;
			@(negedge sys_clk) strobe = 1'b0;
		end
	endtask : cal
	// One sample period; a short overflow pulse sits inside it
	task automatic iv();
		logic [3:0] p;
		@(negedge sys_clk) strobe = 1'b1;
		smp = {$urandom, $urandom};
		for (int c = 0; c < N_CHAN; c++)
			if (running && en[c]) begin
				exp_q.push_back({cnt, ((seen[c] | ovf[c]) ? RANGE_OVF : rng[c*3+:3]),
					2'(c), smp[c*16+:16]});
				cnt++;
			end
		seen = ovf;
		lv = 4'($urandom);
		p = 4'($urandom);
		@(negedge sys_clk) strobe = 1'b0;
		@(negedge sys_clk) ovf = lv | p;
		seen |= ovf;
		@(negedge sys_clk) ovf = lv;
		// Idle cycles so every enabled channel leaves before the next strobe
		repeat (2) @(negedge sys_clk);
	endtask : iv
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (pv && pr)
			chk(pd, exp_q.size() ? exp_q.pop_front() : 'x);
		if (cyc == 60000) begin
			n_fail++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(32'h3f73));
		repeat (16) @(negedge sys_clk);
		sys_rst = 1'b0;
		go(3'h0);
		repeat (4) @(negedge sys_clk);
		chk(running, 0);
		chk(mcu, 0);
		cmd(2);
		repeat (2) if (!plr) @(negedge sys_clk);
		chk(plr, 1);
		cmd(4);
		repeat (2) if (!refused) @(negedge sys_clk);
		chk(refused, 1);
		ca = 5'($urandom);
		@(negedge sys_clk);
		chk(24'(cr[27:14]), 24'(CAL_GAIN_INIT));
		chk(24'(cr[13:0]), 24'(CAL_OFFSET_INIT));
		$display("test commands done");
		for (int m = 0; m < 3; m++) begin
			cmd(1);
			cnt = '0;
			chk(conv_rst, 1);
			cmd(3);
			chk(mcu, 1);
			if (m == 0)
				cmd(0);
			else
				go(3'(m));
			if (m == 1)
				trig();
			repeat (200) if (conv_rst) @(negedge sys_clk);
			chk(conv_rst, 0);
			cal();
			chk(sync_oe_n, 24'(m != 2));
			chk(sync_o, 0);
			en = 4'($urandom % 15 + 1);
			for (int c = 0; c < N_CHAN; c++)
				rng[c*3+:3] = 3'($urandom % 6);
			seen = ovf;
			go(m == 0 ? 3'h0 : 3'(m + 2));
			if (m == 1)
				trig();
			repeat (200) if (!running) @(negedge sys_clk);
			chk(running, 1);
			repeat (5) iv();
			pace = 2'h1;
			repeat (6) iv();
			pace = 2'h2;
			repeat (5) iv();
			pace = 2'h1;
			repeat (400) if (exp_q.size() != 0) @(negedge sys_clk);
			chk(24'(exp_q.size()), 0);
			chk(24'(ovs), 24'(seen | ovf));
			pace = 2'h0;
			$display("test start mode %0d done", m);
		end
		report_and_stop();
	end
endmodule : tb
